// file: hdl/hst_transfer_unit.sv
// Execute unit for halfword loads/stores and sign-extended byte/halfword loads.
// Assumes the condition field is already checked by the issuer, and that the
// memory system answers read data and abort combinationally in the transfer cycle,
// on ref_clk.
`timescale 1ns/1ns

//Contract
// - Immediate offset is bits 11..8 then 3..0
// - Up flag adds offset, otherwise subtracts
// - Pre-index uses modified base as address
// - Pre-index writes base back only when flagged
// - Post-index always writes the modified base back
// - Sign clear, half set: unsigned halfword transfer
// - Sign set loads signed byte or halfword
// - Signed byte fills upper bits with bit 7
// - Signed halfword fills upper bits with bit 15
// - Little endian byte lanes climb with address
// - Little endian halfword: low lanes, then high
// - Big endian byte lanes descend with address
// - Big endian halfword: high lanes, then low
// - Unsigned halfword load clears upper sixteen bits
// - Store replicates low halfword on both halves
// - Program counter base reads instruction plus eight
// - Program counter stored as instruction plus twelve
// - Abort during transfer takes the data abort trap
// - Load 1S+1N+1I, PC load 2S+2N+1I, store 2N
module hst_transfer_unit
    import hst_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        start,
    input  wire hst_req_t    req,
    input  wire logic        endian_order_select,
    input  wire logic [31:0] mem_rdata,
    input  wire logic        mem_abort,
    output hst_mem_t         mem,
    output logic             busy,
    output logic             done,
    output logic             data_abort,
    output logic             dest_we,
    output logic [3:0]       dest_idx,
    output logic [31:0]      dest_data,
    output logic             base_we,
    output logic [3:0]       base_idx,
    output logic [31:0]      base_data
);

    hst_state_t  state_reg,     state_next;
    hst_mem_t    mem_reg,       mem_next;
    logic        done_reg,      done_next;
    logic        abort_reg,     abort_next;
    logic        dest_we_reg,   dest_we_next;
    logic [3:0]  dest_idx_reg,  dest_idx_next;
    logic [31:0] dest_data_reg, dest_data_next;
    logic        base_we_reg,   base_we_next;
    logic [3:0]  base_idx_reg,  base_idx_next;
    logic [31:0] base_data_reg, base_data_next;
    logic        wb_reg,        wb_next;
    logic        signed_reg,    signed_next;
    logic [31:0] mod_base_reg,  mod_base_next;
    logic        busy_reg,      busy_next;

    logic [31:0] instr;
    logic [7:0]  imm_offset;
    logic [31:0] offset;
    logic [31:0] base_eff;
    logic [31:0] modified;
    logic [31:0] store_src;
    logic        legal;
    logic [1:0]  byte_lane;
    logic        half_lane;
    logic [7:0]  sel_byte;
    logic [15:0] sel_half;
    logic [31:0] load_value;
    logic        is_class;
    logic        has_marks;
    logic        is_kind;
    logic        no_signed_store;
    logic        pc_base;
    logic        pc_src;
    logic        pc_dest;
    logic [7:0]  lane_byte [4];
    logic [15:0] lane_half [2];

    // Every bus lane as its own entry, so lane choice below is a plain index
    for (genvar g = 0; g < 4; g++) begin : g_byte_lane
        assign lane_byte[g] = mem_rdata[8*g +: 8];
    end

    for (genvar g = 0; g < 2; g++) begin : g_half_lane
        assign lane_half[g] = mem_rdata[16*g +: 16];
    end

    // Decode and address formation, all from the request seen with start
    always_comb begin
        instr      = req.instr;
        imm_offset = {instr[OFS_HI_MSB:OFS_HI_LSB], instr[OFS_LO_MSB:OFS_LO_LSB]};
        offset     = instr[BIT_IMM] ? {24'h000000, imm_offset} : req.offset_value;
        pc_base    = (instr[BASE_MSB:BASE_LSB] == PC_INDEX);
        pc_src     = (instr[DEST_MSB:DEST_LSB] == PC_INDEX);
        // Pipeline view of the program counter as a base
        base_eff   = pc_base ? req.instr_addr + PC_BASE_AHEAD : req.base_value;
        modified   = instr[BIT_UP] ? base_eff + offset : base_eff - offset;
        // Only the low half of this reaches the bus
        store_src  = pc_src ? req.instr_addr + PC_STORE_AHEAD : req.source_value;
        // Signed stores and the swap/multiply space (sign=half=0) are not ours
        is_class        = (instr[CLASS_MSB:CLASS_LSB] == CLASS_CODE);
        has_marks       = instr[BIT_MARK_HI] & instr[BIT_MARK_LO];
        is_kind         = instr[BIT_SIGN] | instr[BIT_HALF];
        no_signed_store = instr[BIT_LOAD] | ~instr[BIT_SIGN];
        // Illegal words get no response at all, so the issuer must not wait on them
        legal      = is_class & has_marks & is_kind & no_signed_store;
    end

    // Lane selection from the registered transfer address
    always_comb begin
        byte_lane = endian_order_select ? ~mem_reg.addr[1:0] : mem_reg.addr[1:0];
        half_lane = endian_order_select ? ~mem_reg.addr[1] : mem_reg.addr[1];
        // Odd halfword addresses read as the even one below
        sel_byte  = lane_byte[byte_lane];
        sel_half  = lane_half[half_lane];
        if (!mem_reg.is_half) begin
            load_value = {{24{sel_byte[7]}}, sel_byte};
        end else if (signed_reg) begin
            load_value = {{16{sel_half[15]}}, sel_half};
        end else begin
            load_value = {16'h0000, sel_half};
        end
    end

    always_comb begin
        state_next     = state_reg;
        mem_next       = mem_reg;
        mem_next.req   = 1'b0;
        mem_next.write = 1'b0;
        done_next      = 1'b0;
        abort_next     = 1'b0;
        dest_we_next   = 1'b0;
        dest_idx_next  = dest_idx_reg;
        dest_data_next = dest_data_reg;
        base_we_next   = 1'b0;
        base_idx_next  = base_idx_reg;
        base_data_next = base_data_reg;
        wb_next        = wb_reg;
        signed_next    = signed_reg;
        mod_base_next  = mod_base_reg;
        pc_dest        = (dest_idx_reg == PC_INDEX);
        case (state_reg)
            HST_IDLE: begin
                mem_next.cyc = CYC_IDLE;
                if (start && legal) begin
                    // Everything is captured now; the request may change after start
                    mem_next.req     = 1'b1;
                    mem_next.write   = ~instr[BIT_LOAD];
                    mem_next.is_half = instr[BIT_HALF];
                    mem_next.addr    = instr[BIT_PRE] ? modified : base_eff;
                    mem_next.wdata   = {store_src[15:0], store_src[15:0]};
                    mem_next.cyc     = CYC_NONSEQ;
                    // Post-index ignores the write-back flag entirely
                    wb_next          = ~instr[BIT_PRE] | instr[BIT_WB];
                    signed_next      = instr[BIT_SIGN];
                    mod_base_next    = modified;
                    dest_idx_next    = instr[DEST_MSB:DEST_LSB];
                    base_idx_next    = instr[BASE_MSB:BASE_LSB];
                    state_next       = instr[BIT_LOAD] ? HST_XFER_LD : HST_XFER_ST;
                end
            end

            HST_XFER_LD: begin
                if (mem_abort) begin
                    // Nothing is committed, so the instruction can be restarted
                    abort_next   = 1'b1;
                    done_next    = 1'b1;
                    mem_next.cyc = CYC_IDLE;
                    state_next   = HST_IDLE;
                end else begin
                    dest_we_next   = 1'b1;
                    dest_data_next = load_value;
                    base_we_next   = wb_reg;
                    base_data_next = mod_base_reg;
                    mem_next.cyc   = CYC_INTERNAL;
                    state_next     = HST_INTERN;
                end
            end

            HST_INTERN: begin
                if (pc_dest) begin
                    mem_next.cyc = CYC_NONSEQ;
                    state_next   = HST_PC_N;
                end else begin
                    mem_next.cyc = CYC_SEQ;
                    state_next   = HST_FETCH_S;
                end
            end

            HST_PC_N: begin
                // Refetch after a loaded program counter: N, then two S
                mem_next.cyc = CYC_SEQ;
                state_next   = HST_PC_S;
            end

            HST_PC_S: begin
                mem_next.cyc = CYC_SEQ;
                state_next   = HST_FETCH_S;
            end

            HST_FETCH_S: begin
                // Last S is the next fetch; the unit is free once it is seen
                done_next    = 1'b1;
                mem_next.cyc = CYC_IDLE;
                state_next   = HST_IDLE;
            end

            HST_XFER_ST: begin
                if (mem_abort) begin
                    // Memory side blocks the write; the base update is skipped as well
                    abort_next   = 1'b1;
                    done_next    = 1'b1;
                    mem_next.cyc = CYC_IDLE;
                    state_next   = HST_IDLE;
                end else begin
                    base_we_next   = wb_reg;
                    base_data_next = mod_base_reg;
                    mem_next.cyc   = CYC_NONSEQ;
                    state_next     = HST_STORE_N;
                end
            end

            HST_STORE_N: begin
                // Second N: the store has left the core
                done_next    = 1'b1;
                mem_next.cyc = CYC_IDLE;
                state_next   = HST_IDLE;
            end

            default: begin
                mem_next.cyc = CYC_IDLE;
                state_next   = HST_IDLE;
            end
        endcase
        // Registered so the status output never glitches through the decode
        busy_next      = (state_next != HST_IDLE);
    end

    // Everything the unit shows is registered, busy included
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg     <= HST_IDLE;
            busy_reg      <= 1'b0;
            mem_reg       <= '{
                req:     1'b0,
                write:   1'b0,
                is_half: 1'b0,
                cyc:     CYC_IDLE,
                addr:    32'h0000_0000,
                wdata:   32'h0000_0000
            };
            done_reg      <= 1'b0;
            abort_reg     <= 1'b0;
            dest_we_reg   <= 1'b0;
            dest_idx_reg  <= 4'h0;
            dest_data_reg <= 32'h0000_0000;
            base_we_reg   <= 1'b0;
            base_idx_reg  <= 4'h0;
            base_data_reg <= 32'h0000_0000;
            wb_reg        <= 1'b0;
            signed_reg    <= 1'b0;
            mod_base_reg  <= 32'h0000_0000;
        end else begin
            state_reg     <= state_next;
            busy_reg      <= busy_next;
            mem_reg       <= mem_next;
            done_reg      <= done_next;
            abort_reg     <= abort_next;
            dest_we_reg   <= dest_we_next;
            dest_idx_reg  <= dest_idx_next;
            dest_data_reg <= dest_data_next;
            base_we_reg   <= base_we_next;
            base_idx_reg  <= base_idx_next;
            base_data_reg <= base_data_next;
            wb_reg        <= wb_next;
            signed_reg    <= signed_next;
            mod_base_reg  <= mod_base_next;
        end
    end

    assign mem        = mem_reg;
    assign busy       = busy_reg;
    assign done       = done_reg;
    assign data_abort = abort_reg;
    assign dest_we    = dest_we_reg;
    assign dest_idx   = dest_idx_reg;
    assign dest_data  = dest_data_reg;
    assign base_we    = base_we_reg;
    assign base_idx   = base_idx_reg;
    assign base_data  = base_data_reg;

endmodule // hst_transfer_unit

// file: hdl/hst_pkg.sv
// Constants and carrier types for the halfword and signed-byte transfer unit.
// Assumes a 32-bit instruction word and a 32-bit synchronous memory data bus.
package hst_pkg;

    localparam int unsigned BIT_PRE       = 24;
    localparam int unsigned BIT_UP        = 23;
    localparam int unsigned BIT_IMM       = 22;
    localparam int unsigned BIT_WB        = 21;
    localparam int unsigned BIT_LOAD      = 20;
    localparam int unsigned BIT_SIGN      = 6;
    localparam int unsigned BIT_HALF      = 5;
    localparam int unsigned BASE_MSB      = 19;
    localparam int unsigned BASE_LSB      = 16;
    localparam int unsigned DEST_MSB      = 15;
    localparam int unsigned DEST_LSB      = 12;
    localparam int unsigned OFS_HI_MSB    = 11;
    localparam int unsigned OFS_HI_LSB    = 8;
    localparam int unsigned OFS_LO_MSB    = 3;
    localparam int unsigned OFS_LO_LSB    = 0;
    localparam int unsigned CLASS_MSB     = 27;
    localparam int unsigned CLASS_LSB     = 25;
    localparam int unsigned BIT_MARK_HI   = 7;
    localparam int unsigned BIT_MARK_LO   = 4;

    localparam logic [2:0]  CLASS_CODE    = 3'h0;
    localparam logic [3:0]  PC_INDEX      = 4'hF;
    localparam logic [31:0] PC_BASE_AHEAD = 32'h0000_0008;
    localparam logic [31:0] PC_STORE_AHEAD = 32'h0000_000C;

    localparam logic [1:0]  CYC_NONSEQ    = 2'h0;
    localparam logic [1:0]  CYC_SEQ       = 2'h1;
    localparam logic [1:0]  CYC_INTERNAL  = 2'h2;
    localparam logic [1:0]  CYC_IDLE      = 2'h3;

    typedef enum logic [7:0] {
        HST_IDLE    = 8'h01,
        HST_XFER_LD = 8'h02,
        HST_INTERN  = 8'h04,
        HST_PC_N    = 8'h08,
        HST_PC_S    = 8'h10,
        HST_FETCH_S = 8'h20,
        HST_XFER_ST = 8'h40,
        HST_STORE_N = 8'h80
    } hst_state_t;

    typedef struct packed {
        logic [31:0] instr;
        logic [31:0] base_value;
        logic [31:0] offset_value;
        logic [31:0] source_value;
        logic [31:0] instr_addr;
    } hst_req_t;

    typedef struct packed {
        logic        req;
        logic        write;
        logic        is_half;
        logic [1:0]  cyc;
        logic [31:0] addr;
        logic [31:0] wdata;
    } hst_mem_t;

endpackage

// file: verif/hst_chk.sv
// Checker for the halfword transfer unit: address, lanes, write-back, timing.
// Bound to hst_transfer_unit and sees only its ports.
`timescale 1ns/1ns
module hst_chk
    import hst_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        start,
    input wire hst_req_t    req,
    input wire logic        endian_order_select,
    input wire logic [31:0] mem_rdata,
    input wire logic        mem_abort,
    input wire hst_mem_t    mem,
    input wire logic        busy,
    input wire logic        done,
    input wire logic        data_abort,
    input wire logic        dest_we,
    input wire logic [31:0] dest_data,
    input wire logic        base_we,
    input wire logic [31:0] base_data
);
    logic [31:0] ins, bv, ofs, wb, ea, sv, bsel;
    logic [15:0] hsel;
    logic        go;
    always_comb begin
        ins = req.instr;
        bv = (ins[19:16] == PC_INDEX) ? req.instr_addr + PC_BASE_AHEAD : req.base_value;
        ofs = ins[22] ? {24'h0, ins[11:8], ins[3:0]} : req.offset_value;
        wb = ins[23] ? bv + ofs : bv - ofs;
        ea = ins[24] ? wb : bv;
        sv = (ins[15:12] == PC_INDEX) ? req.instr_addr + PC_STORE_AHEAD : req.source_value;
        // Only legal encodings are taken, so only they may start a check
        go = start && !busy && ins[27:25] == CLASS_CODE && ins[7] && ins[4]
            && (ins[6] || ins[5]) && (ins[20] || !ins[6]);
        hsel = (endian_order_select ^ mem.addr[1]) ? mem_rdata[31:16] : mem_rdata[15:0];
        bsel = mem_rdata >> {mem.addr[1:0] ^ {2{endian_order_select}}, 3'h0};
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    sequence s_xfer;
        mem.req && !mem_abort;
    endsequence
    sequence s_ld_tail;
        mem.cyc == CYC_INTERNAL && dest_we ##1 mem.cyc == CYC_SEQ ##1 done;
    endsequence
    property p_addr;
        go |=> mem.req && mem.addr == $past(ea);
    endproperty
    a_addr: assert property (p_addr) else $error("transfer address wrong");
    property p_wdata;
        go && !ins[20] |=> mem.write && mem.wdata == {2{$past(sv[15:0])}};
    endproperty
    a_wdata: assert property (p_wdata) else $error("store data wrong");
    property p_ld_time;
        go && ins[20] && ins[15:12] != PC_INDEX ##1 s_xfer |=> s_ld_tail;
    endproperty
    a_ld_time: assert property (p_ld_time) else $error("load cycles wrong");
    property p_st_time;
        go && !ins[20] ##1 s_xfer |=> mem.cyc == CYC_NONSEQ ##1 done;
    endproperty
    a_st_time: assert property (p_st_time) else $error("store cycles wrong");
    property p_abort;
        mem.req && mem_abort |=> data_abort && done && !dest_we && !base_we;
    endproperty
    a_abort: assert property (p_abort) else $error("abort not taken");
    property p_wb;
        go && (!ins[24] || ins[21]) ##1 s_xfer |=> base_we && base_data == $past(wb, 2);
    endproperty
    a_wb: assert property (p_wb) else $error("base write-back wrong");
    property p_no_wb;
        go && ins[24] && !ins[21] |=> !base_we [*3];
    endproperty
    a_no_wb: assert property (p_no_wb) else $error("base written unasked");
    property p_byte;
        s_xfer and !mem.write && !mem.is_half
            |=> dest_data == {{24{$past(bsel[7])}}, $past(bsel[7:0])};
    endproperty
    a_byte: assert property (p_byte) else $error("signed byte wrong");
    property p_half;
        mem.req && !mem_abort && !mem.write && mem.is_half |=> dest_data[15:0] == $past(hsel);
    endproperty
    a_half: assert property (p_half) else $error("halfword lane wrong");
endmodule // hst_chk

// file: verif/hst_mem_model.sv
// Memory system model: one word cell, halfword write enables, abort on demand.
// Answers combinationally in the transfer cycle, as the unit expects.
`timescale 1ns/1ns
module hst_mem_model
    import hst_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire hst_mem_t    mem,
    input  wire logic        endian_order_select,
    input  wire logic        fault,
    output logic [31:0]      mem_rdata,
    output logic             mem_abort
);
    logic [31:0] word_reg = 32'h0;
    logic        hi;
    assign hi = mem.addr[1] ^ endian_order_select;
    // Outside a read the bus shows the inverse so stale data never passes
    assign mem_rdata = (mem.req && !mem.write) ? word_reg : ~word_reg;
    assign mem_abort = mem.req && fault;
    always_ff @(posedge ref_clk) begin
        if (mem.req && mem.write && !fault) begin
            if (hi) word_reg[31:16] <= mem.wdata[31:16];
            else word_reg[15:0] <= mem.wdata[15:0];
        end
    end
endmodule // hst_mem_model

// file: verif/hst_transfer_unit_test.sv
// Testbench: stores build a word, then loads, indexing, PC and abort cases.
// Instruction address is fixed at 0200; halfword addresses stay aligned, byte loads use all four lanes.
`timescale 1ns/1ns
module hst_transfer_unit_test
    import hst_pkg::*;
;
    localparam logic [31:0] WORD = 32'h7E02_80F1;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        start = 1'b0;
    logic        endian_order_select = 1'b0;
    logic        fault = 1'b0;
    hst_req_t    req = '0;
    hst_mem_t    mem;
    logic [31:0] mem_rdata, dest_data, base_data, a_s, w_s, d_s, b_s, bt, hw;
    logic        mem_abort, busy, done, data_abort, dest_we, base_we, ab_s, dw_s, bw_s;
    logic [3:0]  dest_idx, base_idx, di_s, bi_s;
    logic [4:0]  md [4] = '{5'b11101, 5'b10111, 5'b01101, 5'b00001};
    logic [31:0] ea [4] = '{32'h10A4, 32'h0F5C, 32'h1000, 32'h1000};
    logic [31:0] eb [4] = '{32'h10A4, 32'h0F5C, 32'h10A4, 32'h0FF0};
    int          failures = 0;
    int          cmp_count = 0;
    int          cyc;
    always #4 ref_clk = ~ref_clk;
    hst_transfer_unit dut_u (.ref_clk, .rst, .start, .req, .endian_order_select, .mem_rdata,
        .mem_abort, .mem, .busy, .done, .data_abort, .dest_we, .dest_idx, .dest_data,
        .base_we, .base_idx, .base_data);
    hst_mem_model mem_u (.ref_clk, .mem, .endian_order_select, .fault, .mem_rdata, .mem_abort);
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic [31:0] enc(input logic [4:0] f, input logic [3:0] rn, rd,
                                        input logic [1:0] sh, input logic [7:0] o);
        return {4'hE, 3'h0, f, rn, rd, o[7:4], 1'b1, sh, 1'b1, o[3:0]};
    endfunction
    task automatic run(input logic [31:0] ins, bv, ov, sv);
        @(posedge ref_clk);
        start <= 1'b1;
        req <= '{ins, bv, ov, sv, 32'h0000_0200};
        @(posedge ref_clk);
        start <= 1'b0;
        {ab_s, dw_s, bw_s} = 3'h0;
        // Bounded: a hang shows up as a wrong cycle count
        for (cyc = 0; cyc < 12; cyc++) begin
            #1;
            if (mem.req === 1'b1) {a_s, w_s} = {mem.addr, mem.wdata};
            if (dest_we === 1'b1) {dw_s, d_s, di_s} = {1'b1, dest_data, dest_idx};
            if (base_we === 1'b1) {bw_s, b_s, bi_s} = {1'b1, base_data, base_idx};
            if (done === 1'b1) begin
                ab_s = data_abort;
                break;
            end
            @(posedge ref_clk);
        end
    endtask
    task automatic end_sim;
        $display("Comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        run(enc(5'b11100, 4'h1, 4'h2, 2'b01, 8'h00), 32'h100, 0, 32'h1234_80F1);
        chk("st_cycles", 2, cyc);
        chk("st_wdata", 32'h80F1_80F1, w_s);
        run(enc(5'b11100, 4'h1, 4'h2, 2'b01, 8'h02), 32'h100, 0, 32'h0000_7E02);
        for (int e = 0; e < 2; e++) begin
            endian_order_select <= e[0];
            for (int l = 0; l < 4; l++) begin
                run(enc(5'b11101, 4'h1, 4'h3, 2'b10, 8'h00), 32'h100 + l, 0, 0);
                bt = WORD >> (8 * (e ? 3 - l : l));
                chk("ld_sbyte", {{24{bt[7]}}, bt[7:0]}, d_s);
            end
            for (int l = 0; l < 4; l++) begin
                run(enc(5'b11101, 4'h1, 4'h3, {l[1], 1'b1}, 8'h00), 32'h100 + 2 * l[0], 0, 0);
                hw = WORD >> (16 * (e ^ l[0]));
                chk("ld_half", {l[1] ? {16{hw[15]}} : 16'h0, hw[15:0]}, d_s);
                chk("ld_cycles", 3, cyc);
            end
        end
        for (int i = 0; i < 4; i++) begin
            run(enc(md[i], 4'h1, 4'h3, 2'b01, md[i][2] ? 8'hA4 : 8'h05), 32'h1000, 32'h10, 0);
            chk("addr", ea[i], a_s);
            chk("wb", {31'h0, !md[i][4] | md[i][1]}, {31'h0, bw_s});
            if (bw_s === 1'b1) chk("base", eb[i], b_s);
            if (bw_s === 1'b1) chk("base_idx", 32'h1, {28'h0, bi_s});
            chk("dest_idx", 32'h3, {28'h0, di_s});
        end
        run(enc(5'b11101, 4'hF, 4'h3, 2'b01, 8'h04), 0, 0, 0);
        chk("pc_base", 32'h020C, a_s);
        run(enc(5'b11101, 4'h1, 4'hF, 2'b01, 8'h00), 32'h100, 0, 0);
        chk("pc_ld_cycles", 5, cyc);
        run(enc(5'b11100, 4'h1, 4'hF, 2'b01, 8'h00), 32'h100, 0, 0);
        chk("pc_store", 32'h020C_020C, w_s);
        fault <= 1'b1;
        run(enc(5'b01101, 4'h1, 4'h3, 2'b11, 8'h04), 32'h100, 0, 0);
        fault <= 1'b0;
        chk("abort", 32'h4, {29'h0, ab_s, dw_s, bw_s});
        end_sim();
    end
    // 26 transfers of under 8 cycles each; a wide margin before giving up
    initial begin
        #20000;
        failures++;
        end_sim();
    end
endmodule // hst_transfer_unit_test
bind hst_transfer_unit hst_chk chk_u (.ref_clk, .rst, .start, .req, .endian_order_select,
    .mem_rdata, .mem_abort, .mem, .busy, .done, .data_abort, .dest_we, .dest_data,
    .base_we, .base_data);
